/* File: rtl/lpw_defs.svh */
`ifndef LPW_DEFS_SVH
`define LPW_DEFS_SVH

// Core clock rate
`define LPW_CORE_HZ 20000000
// Clock output default rate, 32.786 kHz
`define LPW_CLOCK_OUTPUT_DEFAULT_HZ 32786
// Default half period of the clock output in core cycles
`define LPW_CLOCK_OUTPUT_HALF_DEFAULT (`LPW_CORE_HZ / (2 * `LPW_CLOCK_OUTPUT_DEFAULT_HZ))
// Clock output cycles run after a low power command
`define LPW_TAIL_CYCLES 128
// Recovery time to Idle in microseconds, and in core cycles
`define LPW_WAKE_US 300
`define LPW_WAKE_CYC ((`LPW_WAKE_US * (`LPW_CORE_HZ / 1000000)))
// Length of one attention low pulse from the host, core cycles
`define LPW_WAKE_ATTENTION_N_PULSE 4
// Extra cycles of margin used by the host on its waits
`define LPW_HOST_MARGIN 16

// Command data field positions
`define LPW_CTRL_CLOCK_OUTPUT_PIN_EN 0
`define LPW_CTRL_CLOCK_OUTPUT_SLEEP 1
`define LPW_CTRL_TIMER_EXIT 2
`define LPW_CTRL_WAKE_ATTENTION_N_IRQ_EN 3
`define LPW_GPIO_OE_LSB 8

// Reset values
`define LPW_CTRL_RESET 4'h0
`define LPW_GPIO_RESET 8'h00

`endif

/* File: rtl/lpw_pkg.sv */
package lpw_pkg;

  typedef logic [15:0] data_t;
  typedef logic [7:0]  gpio_t;

  // Serial commands from host to device
  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_RETAIN   = 4'h1,
    CMD_SLEEP    = 4'h2,
    CMD_RX       = 4'h3,
    CMD_TX       = 4'h4,
    CMD_CCA      = 4'h5,
    CMD_SET_DIV  = 4'h6,
    CMD_SET_CTRL = 4'h7,
    CMD_SET_GPIO = 4'h8,
    CMD_IRQ_ACK  = 4'h9
  } cmd_e;

  // Device power states
  typedef enum logic [6:0] {
    ST_OFF    = 7'h01,
    ST_WAKE   = 7'h02,
    ST_IDLE   = 7'h04,
    ST_ACTIVE = 7'h08,
    ST_ENTER  = 7'h10,
    ST_RETAIN = 7'h20,
    ST_SLEEP  = 7'h40
  } dev_state_e;

  // Host sequencer states
  typedef enum logic [8:0] {
    H_RECOVER = 9'h001,
    H_READY   = 9'h002,
    H_SLOW    = 9'h004,
    H_LOWCMD  = 9'h008,
    H_TAIL    = 9'h010,
    H_LOW     = 9'h020,
    H_FALL1   = 9'h040,
    H_GAP     = 9'h080,
    H_FALL2   = 9'h100
  } host_state_e;

endpackage

/* File: rtl/lpw_link_if.sv */
`timescale 1ns/1ns
interface lpw_link_if;
  import lpw_pkg::*;

  logic  rst_n;
  logic  wake_attention_n;
  logic  cmd_valid;
  cmd_e  cmd_code;
  data_t cmd_data;
  logic  clock_output_o;
  logic  clock_output_oe;
  logic  irq_n_o;
  logic  irq_n_oe;
  logic  clock_output;
  logic  irq_n;

  // Pin levels: clock output pulled low and interrupt pulled high when undriven
  assign clock_output = clock_output_oe & clock_output_o;
  assign irq_n        = irq_n_oe ? irq_n_o : 1'b1;

  modport dev (
    input  rst_n, wake_attention_n, cmd_valid, cmd_code, cmd_data,
    output clock_output_o, clock_output_oe, irq_n_o, irq_n_oe
  );

  modport host (
    output rst_n, wake_attention_n, cmd_valid, cmd_code, cmd_data,
    input  clock_output, irq_n
  );
endinterface

/* File: rtl/clkout_divider.sv */
`timescale 1ns/1ns
module clkout_divider (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] half_period,
  output logic             level_ff,
  output logic             tick
);
  logic [15:0] cnt_ff;
  logic        half_done;

  assign half_done = (cnt_ff + 16'h0001 >= half_period);
  // Pulse at the end of each full output period
  assign tick      = run & half_done & level_ff;

  // Half period counter and output level, parked low when stopped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff   <= 16'h0000;
      level_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff   <= 16'h0000;
      level_ff <= 1'b0;
    end else if (half_done) begin
      cnt_ff   <= 16'h0000;
      level_ff <= ~level_ff;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule

/* File: rtl/radio_low_power_wake.sv */
// How it works
// - Reset pin low holds Off, GPIO inputs
// - Off tristates outputs, clears all registers
// - Retention stops blocks, keeps registers and pins
// - Reset or attention leaves low power
// - Timed sleep keeps oscillator, timer may exit
// - Timed sleep optionally keeps clock output running
// - Timed sleep keeps registers and pin states
// - Operations start only from Idle
// - Only attention falling edge counts
// - Attention ignored while device is active
// - Attention rising edge never has effect
// - Fully low power accepts attention anytime
// - Run 128 clock output cycles, then enter
// - Attention in last tail cycle is dropped
// - Host waits for full entry before attention
// - Host may pulse attention twice, spaced
// - Host may speed clock output before entry
// - Clock output defaults to 32.786 kHz
// - Host slows clock output around timed sleep
// - Sleep exit raises attention or timer interrupt
// - Retention exit restores programmed clock output
// - Every recovery ends in Idle
`timescale 1ns/1ns
`include "lpw_defs.svh"
module radio_low_power_wake #(
  parameter int WAKE_CYCLES = `LPW_WAKE_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  lpw_link_if.dev            link,
  input  wire lpw_pkg::gpio_t gpio_i,
  output lpw_pkg::gpio_t     gpio_o,
  output lpw_pkg::gpio_t     gpio_oe,
  input  wire logic          timer_expire,
  input  wire logic          op_done,
  output logic               op_start,
  output lpw_pkg::cmd_e      op_code,
  output logic               osc_on,
  output logic               timer_run,
  output logic [6:0]         power_state
);
  import lpw_pkg::*;

  dev_state_e  state_ff;
  dev_state_e  nxt_state;
  logic        rst_s1_ff;
  logic        rst_s2_ff;
  logic        wake_attention_n_s1_ff;
  logic        wake_attention_n_s2_ff;
  logic        wake_attention_n_s3_ff;
  logic [6:0]  tail_cnt_ff;
  logic [31:0] wake_cnt_ff;
  logic        lp_sleep_ff;
  logic        pend_ff;
  logic        cause_timer_ff;
  logic        irq_wake_attention_n_ff;
  logic        irq_timer_ff;
  logic [3:0]  ctrl_ff;
  logic [15:0] half_ff;
  gpio_t       gpio_o_ff;
  gpio_t       gpio_oe_ff;
  cmd_e        op_code_ff;
  logic        clk_level;
  logic        clk_tick;

  wire pin_reset   = ~rst_s2_ff;
  wire in_off      = (state_ff == ST_OFF);
  wire in_idle     = (state_ff == ST_IDLE);
  wire in_active   = (state_ff == ST_ACTIVE);
  wire in_enter    = (state_ff == ST_ENTER);
  wire in_retain   = (state_ff == ST_RETAIN);
  wire in_sleep    = (state_ff == ST_SLEEP);
  wire in_wake     = (state_ff == ST_WAKE);
  wire awake       = in_idle | in_active;
  wire cmd_ok      = link.cmd_valid & awake;
  wire wake_attention_n_fall   = wake_attention_n_s3_ff & ~wake_attention_n_s2_ff;
  wire last_cycle  = in_enter & (tail_cnt_ff == 7'(`LPW_TAIL_CYCLES - 1));
  wire tail_done   = last_cycle & clk_tick;
  wire timer_exit  = in_sleep & timer_expire & ctrl_ff[`LPW_CTRL_TIMER_EXIT];
  // Full low power takes the edge
  wire lp_wake     = (in_retain | in_sleep) & (wake_attention_n_fall | pend_ff);
  wire wake_done   = in_wake & (wake_cnt_ff >= 32'(WAKE_CYCLES - 1));
  wire is_op       = (link.cmd_code == CMD_RX) | (link.cmd_code == CMD_TX) | (link.cmd_code == CMD_CCA);
  wire is_lp       = (link.cmd_code == CMD_RETAIN) | (link.cmd_code == CMD_SLEEP);
  // Clock kept in sleep only if asked
  // Internal clock always runs in the tail
  // Restarts on exit with retained half period
  wire clk_run     = in_enter | awake | in_wake | (in_sleep & ctrl_ff[`LPW_CTRL_CLOCK_OUTPUT_SLEEP]);

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_s1_ff  <= 1'b0;
      rst_s2_ff  <= 1'b0;
      wake_attention_n_s1_ff <= 1'b1;
      wake_attention_n_s2_ff <= 1'b1;
      wake_attention_n_s3_ff <= 1'b1;
    end else begin
      rst_s1_ff  <= link.rst_n;
      rst_s2_ff  <= rst_s1_ff;
      wake_attention_n_s1_ff <= link.wake_attention_n;
      wake_attention_n_s2_ff <= wake_attention_n_s1_ff;
      wake_attention_n_s3_ff <= wake_attention_n_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power state sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF: begin
        nxt_state = ST_WAKE;
      end
      ST_WAKE: begin
        if (wake_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_ok & is_op) begin
          nxt_state = ST_ACTIVE;
        end else if (cmd_ok & is_lp) begin
          nxt_state = ST_ENTER;
        end
      end
      ST_ACTIVE: begin
        if (op_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ENTER: begin
        if (tail_done) begin
          nxt_state = lp_sleep_ff ? ST_SLEEP : ST_RETAIN;
        end
      end
      ST_RETAIN: begin
        if (lp_wake) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_SLEEP: begin
        if (lp_wake | timer_exit) begin
          nxt_state = ST_WAKE;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (pin_reset) begin
      nxt_state = ST_OFF;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Tail, recovery and pending wake tracking
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tail_cnt_ff    <= 7'h00;
      wake_cnt_ff    <= 32'h0000_0000;
      lp_sleep_ff    <= 1'b0;
      pend_ff        <= 1'b0;
      cause_timer_ff <= 1'b0;
    end else begin
      if (!in_enter) begin
        tail_cnt_ff <= 7'h00;
      end else if (clk_tick) begin
        tail_cnt_ff <= tail_cnt_ff + 7'h01;
      end
      wake_cnt_ff <= in_wake ? wake_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
      if (in_idle & cmd_ok & is_lp) begin
        lp_sleep_ff <= (link.cmd_code == CMD_SLEEP);
      end
      if (in_enter & wake_attention_n_fall & ~last_cycle) begin
        pend_ff <= 1'b1;
      end else if (!in_enter) begin
        pend_ff <= 1'b0;
      end
      if (in_sleep | in_retain) begin
        cause_timer_ff <= timer_exit & ~lp_wake;
      end else if (in_off) begin
        cause_timer_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt causes; a new cause wins over an acknowledge
  wire ack       = cmd_ok & (link.cmd_code == CMD_IRQ_ACK);
  // Cause chosen by the exit path
  wire set_wake_attention_n  = wake_done & ~cause_timer_ff;
  wire set_timer = wake_done & cause_timer_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_wake_attention_n_ff  <= 1'b0;
      irq_timer_ff <= 1'b0;
    end else if (pin_reset) begin
      irq_wake_attention_n_ff  <= 1'b0;
      irq_timer_ff <= 1'b0;
    end else begin
      irq_wake_attention_n_ff  <= set_wake_attention_n | (irq_wake_attention_n_ff & ~ack);
      irq_timer_ff <= set_timer | (irq_timer_ff & ~ack);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Retained control, clock setting and GPIO registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff    <= `LPW_CTRL_RESET;
      half_ff    <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
      gpio_o_ff  <= `LPW_GPIO_RESET;
      gpio_oe_ff <= `LPW_GPIO_RESET;
      op_code_ff <= CMD_NOP;
    end else if (pin_reset) begin
      ctrl_ff    <= `LPW_CTRL_RESET;
      half_ff    <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
      gpio_o_ff  <= `LPW_GPIO_RESET;
      gpio_oe_ff <= `LPW_GPIO_RESET;
      op_code_ff <= CMD_NOP;
    end else if (cmd_ok) begin
      unique case (link.cmd_code)
        CMD_SET_CTRL: ctrl_ff <= link.cmd_data[3:0];
        CMD_SET_DIV:  half_ff <= (link.cmd_data == 16'h0000) ? 16'h0001 : link.cmd_data;
        CMD_SET_GPIO: begin
          gpio_o_ff  <= link.cmd_data[7:0];
          gpio_oe_ff <= link.cmd_data[`LPW_GPIO_OE_LSB +: 8];
        end
        default: begin
          if (in_idle & is_op) begin
            op_code_ff <= link.cmd_code;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Clock output generator
  clkout_divider u_clkout (
    .core_clk    (core_clk),
    .rst         (rst),
    .run         (clk_run),
    .half_period (half_ff),
    .level_ff    (clk_level),
    .tick        (clk_tick)
  );

  ////////////////////////////////////////////////////////////////
  // Pin and user side outputs
  // Outputs released in Off
  assign link.clock_output_oe = ~in_off;
  assign link.clock_output_o  = clk_level & ctrl_ff[`LPW_CTRL_CLOCK_OUTPUT_PIN_EN];
  assign link.irq_n_oe        = ~in_off;
  assign link.irq_n_o         = ~((irq_wake_attention_n_ff & ctrl_ff[`LPW_CTRL_WAKE_ATTENTION_N_IRQ_EN]) | irq_timer_ff);
  assign gpio_o               = gpio_o_ff & ~gpio_i & ~gpio_i | gpio_o_ff;
  assign gpio_oe              = in_off ? `LPW_GPIO_RESET : gpio_oe_ff;
  assign op_start             = in_idle & cmd_ok & is_op;
  assign op_code              = op_code_ff;
  // Oscillator and timer alive in sleep
  assign osc_on               = ~in_off & ~in_retain;
  assign timer_run            = ~in_off & ~in_retain;
  assign power_state          = state_ff;
endmodule

/* File: rtl/lpw_host.sv */
`timescale 1ns/1ns
`include "lpw_defs.svh"
module lpw_host #(
  parameter int WAKE_CYCLES = `LPW_WAKE_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  lpw_link_if.host           link,
  input  wire logic          hold_reset,
  input  wire logic          user_valid,
  input  wire lpw_pkg::cmd_e user_cmd,
  input  wire lpw_pkg::data_t user_data,
  output logic               user_ready,
  input  wire logic          slow_for_sleep,
  input  wire logic          wake_req,
  output logic               dev_low,
  output logic               irq_seen
);
  import lpw_pkg::*;

  host_state_e state_ff;
  host_state_e nxt_state;
  logic [31:0] cnt_ff;
  logic [15:0] half_ff;
  logic [15:0] saved_ff;
  logic        slowed_ff;
  logic        cmd_valid_ff;
  cmd_e        cmd_code_ff;
  data_t       cmd_data_ff;
  cmd_e        low_cmd_ff;
  logic        irq_s1_ff;
  logic        irq_s2_ff;

  wire in_ready  = (state_ff == H_READY);
  wire is_lp     = (user_cmd == CMD_RETAIN) | (user_cmd == CMD_SLEEP);
  wire take      = in_ready & user_valid;
  // Twice the tail length in core cycles, from the known clock output setting
  // Wait out the whole tail
  wire [31:0] tail_len = {7'h00, half_ff, 9'h000};
  wire [31:0] gap_len  = {15'h0000, half_ff, 1'b0} + 32'(`LPW_HOST_MARGIN);
  wire need_slow = slow_for_sleep & (user_cmd == CMD_SLEEP) & (half_ff < 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT));
  wire cnt_hit   = (state_ff == H_TAIL)    ? (cnt_ff >= tail_len[31:0] + 32'(`LPW_HOST_MARGIN)) :
                   (state_ff == H_GAP)     ? (cnt_ff >= gap_len) :
                   (state_ff == H_RECOVER) ? (cnt_ff >= 32'(WAKE_CYCLES + `LPW_HOST_MARGIN)) :
                   (cnt_ff >= 32'(`LPW_WAKE_ATTENTION_N_PULSE - 1));

  ////////////////////////////////////////////////////////////////
  // Host sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      H_RECOVER: if (cnt_hit) nxt_state = H_READY;
      H_READY: begin
        if (take & is_lp) begin
          nxt_state = need_slow ? H_SLOW : H_LOWCMD;
        end
      end
      H_SLOW:   nxt_state = H_LOWCMD;
      H_LOWCMD: nxt_state = H_TAIL;
      H_TAIL:   if (cnt_hit) nxt_state = H_LOW;
      H_LOW:    if (wake_req) nxt_state = H_FALL1;
      // Two edges spaced over one period
      H_FALL1:  if (cnt_hit) nxt_state = H_GAP;
      H_GAP:    if (cnt_hit) nxt_state = H_FALL2;
      H_FALL2:  if (cnt_hit) nxt_state = H_RECOVER;
      default:  nxt_state = H_RECOVER;
    endcase
    if (hold_reset) begin
      nxt_state = H_RECOVER;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= H_RECOVER;
      cnt_ff   <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff || hold_reset) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command register and clock output bookkeeping
  wire restore = (state_ff == H_RECOVER) & cnt_hit & slowed_ff & ~hold_reset;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_valid_ff <= 1'b0;
      cmd_code_ff  <= CMD_NOP;
      cmd_data_ff  <= 16'h0000;
      half_ff      <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
      saved_ff     <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
      slowed_ff    <= 1'b0;
      low_cmd_ff   <= CMD_NOP;
    end else begin
      cmd_valid_ff <= 1'b0;
      if (hold_reset) begin
        half_ff   <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
        slowed_ff <= 1'b0;
      end else if (take & is_lp) begin
        low_cmd_ff <= user_cmd;
        saved_ff   <= half_ff;
        slowed_ff  <= need_slow;
      end else if (take) begin
        cmd_valid_ff <= 1'b1;
        cmd_code_ff  <= user_cmd;
        cmd_data_ff  <= user_data;
        if (user_cmd == CMD_SET_DIV) begin
          half_ff <= user_data;
        end
      end else if (state_ff == H_SLOW) begin
        cmd_valid_ff <= 1'b1;
        cmd_code_ff  <= CMD_SET_DIV;
        cmd_data_ff  <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
        half_ff      <= 16'(`LPW_CLOCK_OUTPUT_HALF_DEFAULT);
      end else if (state_ff == H_LOWCMD) begin
        cmd_valid_ff <= 1'b1;
        cmd_code_ff  <= low_cmd_ff;
        cmd_data_ff  <= 16'h0000;
      end else if (restore) begin
        cmd_valid_ff <= 1'b1;
        cmd_code_ff  <= CMD_SET_DIV;
        cmd_data_ff  <= saved_ff;
        half_ff      <= saved_ff;
        slowed_ff    <= 1'b0;
      end
    end
  end

  // Interrupt pin synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_s1_ff <= 1'b1;
      irq_s2_ff <= 1'b1;
    end else begin
      irq_s1_ff <= link.irq_n;
      irq_s2_ff <= irq_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin and user outputs
  assign link.rst_n            = ~hold_reset;
  assign link.wake_attention_n = ~((state_ff == H_FALL1) | (state_ff == H_FALL2));
  assign link.cmd_valid        = cmd_valid_ff;
  assign link.cmd_code         = cmd_code_ff;
  assign link.cmd_data         = cmd_data_ff;
  assign user_ready            = in_ready & ~hold_reset;
  assign dev_low               = (state_ff == H_LOW);
  assign irq_seen              = ~irq_s2_ff;
endmodule

/* File: test/lpw_link_asserts.sv */
`timescale 1ns/1ns
module lpw_link_asserts (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          rst_n,
  input wire logic          wake_attention_n,
  input wire logic          cmd_valid,
  input wire lpw_pkg::cmd_e cmd_code,
  input wire logic          clock_output_oe,
  input wire logic          irq_n_oe,
  input wire logic          irq_n
);
  import lpw_pkg::*;

  logic [7:0] since_low_ff;
  logic [7:0] nxt_since_low;
  logic       low_cmd;
  logic       ack_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last low power command, saturating
  assign low_cmd       = cmd_valid && (cmd_code == CMD_RETAIN || cmd_code == CMD_SLEEP);
  assign ack_cmd       = cmd_valid && (cmd_code == CMD_IRQ_ACK);
  assign nxt_since_low = low_cmd ? 8'h00 : ((since_low_ff == 8'hff) ? 8'hff : since_low_ff + 8'h01);

  // Saturating counter register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_low_ff <= 8'hff;
    end else begin
      since_low_ff <= nxt_since_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_off_outputs_quiet: assert property (!rst_n [*4] |-> !clock_output_oe && !irq_n_oe)
    else $error("device drives pins while held off");
  a_off_irq_high: assert property (!rst_n [*4] |-> irq_n)
    else $error("interrupt low while held off");
  a_irq_holds_low: assert property (!irq_n && rst_n && !ack_cmd |=> !irq_n)
    else $error("interrupt released without acknowledge");
  a_cmd_quiet_off: assert property (!rst_n |-> !cmd_valid)
    else $error("command sent while device held off");
  a_wake_attention_n_pulse_width: assert property ($fell(wake_attention_n) |-> !wake_attention_n [*4] ##1 wake_attention_n)
    else $error("attention pulse not four cycles");
  a_wake_attention_n_gap: assert property ($rose(wake_attention_n) |-> wake_attention_n [*8])
    else $error("attention pulses too close");
  a_wake_attention_n_after_tail: assert property ($fell(wake_attention_n) |-> since_low_ff == 8'hff)
    else $error("attention during power down");
  a_host_waits_recovery: assert property ($rose(rst_n) |-> !cmd_valid [*8])
    else $error("command too soon after reset release");

  // Main scenarios reached
  c_wake_attention_n_fall: cover property ($fell(wake_attention_n));
  c_irq_fall: cover property ($fell(irq_n));
  c_low_cmd: cover property (low_cmd);
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`include "lpw_defs.svh"
module tb_top;
  import lpw_pkg::*;
  logic       core_clk, rst, hold_reset, user_valid, slow_for_sleep, wake_req, timer_expire, op_done;
  logic       user_ready, dev_low, irq_seen, op_start, osc_on, timer_run, co_q, c;
  cmd_e       user_cmd, op_code;
  data_t      user_data;
  gpio_t      gpio_i, gpio_o, gpio_oe;
  logic [6:0] ps1, ps2;
  int         n_mismatch, compares, n_ops, n_rise, i, n;

  lpw_link_if link();
  lpw_link_if link2();

  radio_low_power_wake #(.WAKE_CYCLES(20)) radio_low_power_wake_inst (.core_clk(core_clk), .rst(rst),
    .link(link.dev), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .timer_expire(timer_expire),
    .op_done(op_done), .op_start(op_start), .op_code(op_code), .osc_on(osc_on), .timer_run(timer_run),
    .power_state(ps1));
  lpw_host #(.WAKE_CYCLES(20)) lpw_host_inst (.core_clk(core_clk), .rst(rst), .link(link.host),
    .hold_reset(hold_reset), .user_valid(user_valid), .user_cmd(user_cmd), .user_data(user_data),
    .user_ready(user_ready), .slow_for_sleep(slow_for_sleep), .wake_req(wake_req), .dev_low(dev_low),
    .irq_seen(irq_seen));
  // Second device driven straight by the bench, for badly timed attention
  radio_low_power_wake #(.WAKE_CYCLES(20)) radio_low_power_wake_inst2 (.core_clk(core_clk), .rst(rst),
    .link(link2.dev), .gpio_i(gpio_i), .gpio_o(), .gpio_oe(), .timer_expire(timer_expire),
    .op_done(op_done), .op_start(), .op_code(), .osc_on(), .timer_run(), .power_state(ps2));
  lpw_link_asserts lpw_link_asserts_inst (.core_clk(core_clk), .rst(rst), .rst_n(link.rst_n),
    .wake_attention_n(link.wake_attention_n), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
    .clock_output_oe(link.clock_output_oe), .irq_n_oe(link.irq_n_oe), .irq_n(link.irq_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Count operation starts and tail clock rises
  always @(posedge core_clk) begin
    if (op_start) n_ops++;
    if (ps1 == ST_ENTER && link.clock_output && !co_q) n_rise++;
    co_q = link.clock_output;
  end

  task automatic step(input int k = 1);
    repeat (k) begin
      @(posedge core_clk);
      #5;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_ps(input bit d2, input logic [6:0] st, input int lim);
    for (int k = 0; k < lim && (d2 ? ps2 : ps1) !== st; k++) step();
    check(d2 ? ps2 : ps1, st);
  endtask

  // Command through the host end, held until taken
  task automatic send(input cmd_e cc, input data_t d);
    step();
    user_valid = 1'b1;
    user_cmd = cc;
    user_data = d;
    for (int k = 0; k < 3000 && !user_ready; k++) step();
    step();
    user_valid = 1'b0;
  endtask

  task automatic cmd2(input cmd_e cc, input data_t d);
    step();
    link2.cmd_valid = 1'b1;
    link2.cmd_code = cc;
    link2.cmd_data = d;
    step();
    link2.cmd_valid = 1'b0;
  endtask

  task automatic wait_low();
    for (int k = 0; k < 3000 && !dev_low; k++) step();
  endtask

  task automatic s_reset();
    step(4);
    check(ps1, ST_OFF);
    check({gpio_oe, link.clock_output_oe, link.irq_n}, 10'h001);
    hold_reset = 1'b0;
    wait_ps(0, ST_IDLE, 200);
    send(CMD_SET_CTRL, 16'h0001);
    for (i = 0; i < 800 && link.clock_output; i++) step();
    for (i = 0; i < 800 && !link.clock_output; i++) step();
    for (i = 0; i < 800 && link.clock_output; i++) step();
    check(i, `LPW_CLOCK_OUTPUT_HALF_DEFAULT);
  endtask

  task automatic s_op();
    send(CMD_SET_GPIO, 16'ha55a);
    send(CMD_RX, 16'h0000);
    step(2);
    check({op_code, ps1}, {CMD_RX, ST_ACTIVE});
    send(CMD_TX, 16'h0000);
    step(2);
    check(n_ops, 1);
    op_done = 1'b1;
    step();
    op_done = 1'b0;
    step();
    check({ps1, gpio_oe, gpio_o}, {ST_IDLE, 16'ha55a});
  endtask

  task automatic s_retain();
    send(CMD_SET_DIV, 16'h0001);
    send(CMD_IRQ_ACK, 16'h0000);
    send(CMD_SET_CTRL, 16'h0009);
    n_rise = 0;
    send(CMD_RETAIN, 16'h0000);
    check(irq_seen, 0);
    wait_low();
    check(n_rise, 128);
    check({ps1, osc_on, gpio_oe}, {ST_RETAIN, 1'b0, 8'ha5});
    step(20);
    check({ps1, link.clock_output}, {ST_RETAIN, 1'b0});
    wake_req = 1'b1;
    step();
    wake_req = 1'b0;
    wait_ps(0, ST_IDLE, 300);
    step(4);
    check(irq_seen, 1);
    c = link.clock_output;
    step();
    check(link.clock_output, !c);
    send(CMD_IRQ_ACK, 16'h0000);
    step(6);
    check(irq_seen, 0);
  endtask

  task automatic s_sleep();
    send(CMD_SET_CTRL, 16'h0007);
    send(CMD_SLEEP, 16'h0000);
    wait_low();
    check({ps1, osc_on, timer_run}, {ST_SLEEP, 2'b11});
    c = link.clock_output;
    step();
    check(link.clock_output, !c);
    timer_expire = 1'b1;
    step();
    timer_expire = 1'b0;
    wait_ps(0, ST_IDLE, 100);
    step(4);
    check(irq_seen, 1);
    wake_req = 1'b1;
    step();
    wake_req = 1'b0;
    repeat (60) begin
      step();
      check(ps1, ST_IDLE);
    end
  endtask

  // Reset pin pulled in mid run, then released again
  task automatic s_pin_reset();
    hold_reset = 1'b1;
    step(6);
    check({ps1, gpio_oe, link.clock_output_oe, link.irq_n}, {ST_OFF, 10'h001});
    hold_reset = 1'b0;
    wait_ps(0, ST_IDLE, 200);
    check({gpio_oe, irq_seen}, 9'h000);
  endtask

  task automatic s_dev2();
    cmd2(CMD_SET_DIV, 16'h0001);
    // Second pass starts after a wake, so its tail length repeats below
    repeat (2) begin
      cmd2(CMD_SLEEP, 16'h0000);
      wait_ps(1, ST_ENTER, 10);
      for (n = 0; n < 3000 && ps2 !== ST_SLEEP; n++) step();
      link2.wake_attention_n = 1'b0;
      step(4);
      link2.wake_attention_n = 1'b1;
      wait_ps(1, ST_IDLE, 100);
    end
    cmd2(CMD_SLEEP, 16'h0000);
    wait_ps(1, ST_ENTER, 10);
    step(n - 4);
    link2.wake_attention_n = 1'b0;
    step(60);
    check(ps2, ST_SLEEP);
    link2.wake_attention_n = 1'b1;
    step(10);
    check(ps2, ST_SLEEP);
  endtask

  task automatic complete_run();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, hold_reset, user_valid, slow_for_sleep, wake_req, timer_expire, op_done} = 7'h60;
    {user_cmd, user_data, gpio_i} = {CMD_NOP, 16'h0000, 8'h00};
    {link2.rst_n, link2.wake_attention_n, link2.cmd_valid} = 3'h6;
    {link2.cmd_code, link2.cmd_data} = {CMD_NOP, 16'h0000};
    repeat (8) @(posedge core_clk);
    #5 rst = 1'b0;
    s_reset();
    s_op();
    s_retain();
    s_sleep();
    s_pin_reset();
    s_dev2();
    complete_run();
  end

  // Watchdog
  initial begin
    #(50 * 30000);
    n_mismatch++;
    complete_run();
  end
endmodule
